// File: rtl/prlk_pkg.sv
package prlk_pkg;

    // Lock mask shape: one bit per peripheral group
    localparam int          PRLK_MASK_W     = 16;
    localparam int          PRLK_GRP_W      = 4;

    // Key register shape and default unlock sequence
    localparam int          PRLK_KEY_W      = 8;
    localparam int          PRLK_KEY_LEN    = 2;
    localparam int          PRLK_KEY_CNT_W  = 2;
    localparam logic [15:0] PRLK_KEY_SEQ    = 16'hc5a5;  // First key in the low byte

    // Lock mask value after reset: every group protected
    localparam logic [15:0] PRLK_MASK_RST   = 16'hffff;

    // Peripheral data path width
    localparam int          PRLK_DATA_W     = 32;

    // Key register read layout
    localparam int          PRLK_STAT_UNLK  = 0;
    localparam int          PRLK_STAT_CNT   = 1;
    localparam logic [7:0]  PRLK_STAT_RST   = 8'h00;

    // Key recogniser states
    typedef enum logic [1:0] {
        PRLK_ST_LOCKED   = 2'b01,
        PRLK_ST_UNLOCKED = 2'b10
    } prlk_state_type;

endpackage

// File: rtl/prlk_key_seq.sv
`timescale 1ns/1ps
module prlk_key_seq
    import prlk_pkg::*;
#(
    parameter int                          KEY_LEN = PRLK_KEY_LEN,
    parameter logic [KEY_LEN*PRLK_KEY_W-1:0] KEY_SEQ = PRLK_KEY_SEQ
) (
    input  wire logic                      i_clk,       // System clock
    input  wire logic                      i_rst,       // Synchronous reset, active high
    input  wire logic                      i_key_wr,    // Key register write strobe
    input  wire logic [PRLK_KEY_W-1:0]     i_key_data,  // Key register write data
    output logic                           o_unlocked,  // Mask currently modifiable
    output logic [PRLK_KEY_CNT_W-1:0]      o_key_cnt    // Keys matched so far
);

    prlk_state_type              state_r;
    prlk_state_type              state_nxt;
    logic [PRLK_KEY_CNT_W-1:0]   cnt_r;
    logic [PRLK_KEY_CNT_W-1:0]   cnt_nxt;

    // Expected key at a given position of the sequence
    function automatic logic [PRLK_KEY_W-1:0] key_at(input logic [PRLK_KEY_CNT_W-1:0] idx);
        key_at = KEY_SEQ[idx*PRLK_KEY_W +: PRLK_KEY_W];
    endfunction

    // Sequence recognition and relock
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        unique case (state_r)
            PRLK_ST_LOCKED: begin
                if (i_key_wr) begin
                    if (i_key_data == key_at(cnt_r)) begin
                        if (cnt_r == PRLK_KEY_CNT_W'(KEY_LEN - 1)) begin
                            state_nxt = PRLK_ST_UNLOCKED;
                            cnt_nxt   = '0;
                        end else begin
                            cnt_nxt = cnt_r + 1'b1;
                        end
                    end else if (i_key_data == key_at('0)) begin
                        cnt_nxt = PRLK_KEY_CNT_W'(1);
                    end else begin
                        cnt_nxt = '0;
                    end
                end
            end
            PRLK_ST_UNLOCKED: begin
                if (i_key_wr) begin
                    state_nxt = PRLK_ST_LOCKED;
                    cnt_nxt   = '0;
                end
            end
            default: begin
                state_nxt = PRLK_ST_LOCKED;
                cnt_nxt   = '0;
            end
        endcase
    end

    // State registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_r <= PRLK_ST_LOCKED;
            cnt_r   <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    assign o_unlocked = (state_r == PRLK_ST_UNLOCKED);
    assign o_key_cnt  = cnt_r;

endmodule

// File: rtl/prlk_top.sv
`timescale 1ns/1ps
module prlk_top
    import prlk_pkg::*;
#(
    parameter int                            KEY_LEN  = PRLK_KEY_LEN,
    parameter logic [KEY_LEN*PRLK_KEY_W-1:0] KEY_SEQ  = PRLK_KEY_SEQ,
    parameter logic [PRLK_MASK_W-1:0]        MASK_RST = PRLK_MASK_RST
) (
    input  wire logic                     i_clk,          // System clock
    input  wire logic                     i_rst,          // Synchronous reset, active high
    // Key register
    input  wire logic                     i_key_wr,       // Key write strobe
    input  wire logic [PRLK_KEY_W-1:0]    i_key_wdata,    // Key write data
    input  wire logic                     i_key_rd,       // Key read strobe
    output logic [7:0]                    o_key_rdata,    // Key read data, lock status
    output logic                          o_key_rvalid,   // Key read data valid pulse
    // Lock mask register
    input  wire logic                     i_mask_wr,      // Mask write strobe
    input  wire logic [PRLK_MASK_W-1:0]   i_mask_wdata,   // Mask write data
    output logic [PRLK_MASK_W-1:0]        o_peripheral_lock_mask, // Current lock mask
    output logic                          o_mask_wr_rej,  // Mask write refused pulse
    // Peripheral access from firmware
    input  wire logic                     i_per_wr,       // Peripheral write request
    input  wire logic                     i_per_rd,       // Peripheral read request
    input  wire logic [PRLK_GRP_W-1:0]    i_per_grp,      // Group of addressed peripheral
    input  wire logic [PRLK_DATA_W-1:0]   i_per_wdata,    // Peripheral write data
    output logic [PRLK_DATA_W-1:0]        o_per_rdata,    // Read data back to firmware
    output logic                          o_per_rvalid,   // Read data valid pulse
    // Peripheral side
    output logic                          o_per_wr,       // Write passed to peripheral
    output logic                          o_per_rd,       // Read passed to peripheral
    output logic [PRLK_GRP_W-1:0]         o_per_grp,      // Group passed to peripheral
    output logic [PRLK_DATA_W-1:0]        o_per_wdata,    // Write data to peripheral
    input  wire logic [PRLK_DATA_W-1:0]   i_per_rdata,    // Peripheral register contents
    output logic                          o_per_wr_drop   // Write discarded pulse
);

    // Key recogniser status
    logic                        unlocked;
    logic [PRLK_KEY_CNT_W-1:0]   key_cnt;

    // Lock mask and refusal flag
    logic [PRLK_MASK_W-1:0]      mask_r;
    logic [PRLK_MASK_W-1:0]      mask_nxt;
    logic                        mask_rej_r;
    logic                        mask_rej_nxt;

    // Key status read-back
    logic [7:0]                  key_rdata_r;
    logic [7:0]                  key_rdata_nxt;
    logic                        key_rvalid_r;
    logic                        key_rvalid_nxt;

    // Forwarded strobes
    logic                        wr_r;
    logic                        wr_nxt;
    logic                        rd_r;
    logic                        rd_nxt;
    logic                        drop_r;
    logic                        drop_nxt;

    // Forwarded group and write data
    logic [PRLK_GRP_W-1:0]       grp_r;
    logic [PRLK_GRP_W-1:0]       grp_nxt;
    logic [PRLK_DATA_W-1:0]      wdata_r;
    logic [PRLK_DATA_W-1:0]      wdata_nxt;

    // Read data return
    logic [PRLK_DATA_W-1:0]      rdata_r;
    logic [PRLK_DATA_W-1:0]      rdata_nxt;
    logic                        rvalid_r;
    logic                        rvalid_nxt;

    // Whether the mask protects the given group
    function automatic logic grp_locked(input logic [PRLK_MASK_W-1:0] mask,
                                        input logic [PRLK_GRP_W-1:0]  grp);
        grp_locked = mask[grp];
    endfunction

    // Key sequence recogniser
    prlk_key_seq #(
        .KEY_LEN (KEY_LEN),
        .KEY_SEQ (KEY_SEQ)
    ) u_key_seq (
        .i_clk      (i_clk),
        .i_rst      (i_rst),
        .i_key_wr   (i_key_wr),
        .i_key_data (i_key_wdata),
        .o_unlocked (unlocked),
        .o_key_cnt  (key_cnt)
    );

    // Lock mask update, gated by unlock state
    always_comb begin
        mask_nxt     = mask_r;
        mask_rej_nxt = 1'b0;
        if (i_mask_wr) begin
            if (unlocked) begin
                mask_nxt = i_mask_wdata;
            end else begin
                mask_rej_nxt = 1'b1;
            end
        end
    end

    // Key register read status
    always_comb begin
        key_rdata_nxt  = key_rdata_r;
        key_rvalid_nxt = i_key_rd;
        if (i_key_rd) begin
            key_rdata_nxt                                        = PRLK_STAT_RST;
            key_rdata_nxt[PRLK_STAT_UNLK]                        = unlocked;
            key_rdata_nxt[PRLK_STAT_CNT +: PRLK_KEY_CNT_W]       = key_cnt;
        end
    end

    // Peripheral write gating and read forwarding
    always_comb begin
        wr_nxt   = 1'b0;
        drop_nxt = 1'b0;
        rd_nxt   = i_per_rd;
        if (i_per_wr) begin
            if (grp_locked(mask_r, i_per_grp)) begin
                drop_nxt = 1'b1;
            end else begin
                wr_nxt = 1'b1;
            end
        end
    end

    // Group and write data held for the peripheral
    always_comb begin
        grp_nxt   = grp_r;
        wdata_nxt = wdata_r;
        if (i_per_wr || i_per_rd) begin
            grp_nxt = i_per_grp;
        end
        if (i_per_wr && !grp_locked(mask_r, i_per_grp)) begin
            wdata_nxt = i_per_wdata;
        end
    end

    // Read data capture, one cycle after the forwarded read
    always_comb begin
        rvalid_nxt = rd_r;
        rdata_nxt  = rdata_r;
        if (rd_r) begin
            rdata_nxt = i_per_rdata;
        end
    end

    // Lock mask registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mask_r     <= MASK_RST;
            mask_rej_r <= 1'b0;
        end else begin
            mask_r     <= mask_nxt;
            mask_rej_r <= mask_rej_nxt;
        end
    end

    // Key status registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            key_rdata_r  <= PRLK_STAT_RST;
            key_rvalid_r <= 1'b0;
        end else begin
            key_rdata_r  <= key_rdata_nxt;
            key_rvalid_r <= key_rvalid_nxt;
        end
    end

    // Forwarded strobe registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_r   <= 1'b0;
            rd_r   <= 1'b0;
            drop_r <= 1'b0;
        end else begin
            wr_r   <= wr_nxt;
            rd_r   <= rd_nxt;
            drop_r <= drop_nxt;
        end
    end

    // Forwarded group and data registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            grp_r   <= '0;
            wdata_r <= '0;
        end else begin
            grp_r   <= grp_nxt;
            wdata_r <= wdata_nxt;
        end
    end

    // Read return registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_r  <= '0;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // Lock mask and key status outputs
    assign o_peripheral_lock_mask = mask_r;
    assign o_mask_wr_rej          = mask_rej_r;
    assign o_key_rdata            = key_rdata_r;
    assign o_key_rvalid           = key_rvalid_r;

    // Forwarded access to the peripheral
    assign o_per_wr               = wr_r;
    assign o_per_rd               = rd_r;
    assign o_per_grp              = grp_r;
    assign o_per_wdata            = wdata_r;
    assign o_per_wr_drop          = drop_r;

    // Read data back to firmware
    assign o_per_rdata            = rdata_r;
    assign o_per_rvalid           = rvalid_r;

endmodule

// File: dv/prlk_top_properties.sv
`timescale 1ns/1ps
module prlk_top_properties (
    input wire logic        i_clk,                  // Clock
    input wire logic        i_rst,                  // Reset
    input wire logic        i_key_rd,               // Key read
    input wire logic [7:0]  o_key_rdata,            // Key status
    input wire logic        o_key_rvalid,           // Status valid
    input wire logic        i_mask_wr,              // Mask write
    input wire logic [15:0] i_mask_wdata,           // Mask data
    input wire logic [15:0] o_peripheral_lock_mask, // Mask
    input wire logic        o_mask_wr_rej,          // Mask refused
    input wire logic        i_per_wr,               // Write request
    input wire logic        i_per_rd,               // Read request
    input wire logic [3:0]  i_per_grp,              // Group
    input wire logic [31:0] i_per_wdata,            // Write data
    input wire logic [31:0] i_per_rdata,            // Peripheral data
    input wire logic        o_per_wr,               // Write forwarded
    input wire logic        o_per_rd,               // Read forwarded
    input wire logic [3:0]  o_per_grp,              // Forwarded group
    input wire logic [31:0] o_per_wdata,            // Forwarded data
    input wire logic [31:0] o_per_rdata,            // Read data
    input wire logic        o_per_rvalid,           // Read valid
    input wire logic        o_per_wr_drop           // Write dropped
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Status answer and layout
    key_read_a: assert property (i_key_rd |=> o_key_rvalid && o_key_rdata[7:3] == 5'h00)
        else $error("key status answer missing");
    // Reads always forwarded and answered
    read_fwd_a: assert property (i_per_rd |=> o_per_rd ##1 o_per_rvalid)
        else $error("read not completed");
    read_data_a: assert property (o_per_rd |=> o_per_rdata == $past(i_per_rdata))
        else $error("read data not true contents");
    grp_fwd_a: assert property ((i_per_wr || i_per_rd) |=> o_per_grp == $past(i_per_grp))
        else $error("group not forwarded");
    // Locked group writes are dropped
    locked_drop_a: assert property (i_per_wr && o_peripheral_lock_mask[i_per_grp] |=> o_per_wr_drop && !o_per_wr)
        else $error("locked write not dropped");
    // Open group writes pass with their data
    open_pass_a: assert property (i_per_wr && !o_peripheral_lock_mask[i_per_grp]
        |=> o_per_wr && !o_per_wr_drop && o_per_wdata == $past(i_per_wdata))
        else $error("open write not forwarded");
    // Accepted mask writes land as written
    mask_apply_a: assert property (i_mask_wr
        |=> o_mask_wr_rej || o_peripheral_lock_mask == $past(i_mask_wdata))
        else $error("accepted mask write not applied");
    // Mask moves only on a mask write
    mask_hold_a: assert property (!i_mask_wr |=> $stable(o_peripheral_lock_mask))
        else $error("mask changed without write");
    refused_hold_a: assert property (o_mask_wr_rej |-> $stable(o_peripheral_lock_mask))
        else $error("refused write changed mask");
    refuse_cause_a: assert property (o_mask_wr_rej |-> $past(i_mask_wr))
        else $error("refusal without mask write");
    cover property (o_per_wr_drop);
    cover property (o_mask_wr_rej);
    cover property (o_key_rvalid && o_key_rdata[0]);
endmodule
bind prlk_top prlk_top_properties u_prlk_top_properties (.i_clk(i_clk), .i_rst(i_rst), .i_key_rd(i_key_rd),
    .o_key_rdata(o_key_rdata), .o_key_rvalid(o_key_rvalid), .i_mask_wr(i_mask_wr),
    .o_peripheral_lock_mask(o_peripheral_lock_mask), .o_mask_wr_rej(o_mask_wr_rej), .i_per_wr(i_per_wr),
    .i_per_rd(i_per_rd), .i_per_grp(i_per_grp), .i_per_wdata(i_per_wdata), .i_per_rdata(i_per_rdata),
    .o_per_wr(o_per_wr), .o_per_rd(o_per_rd), .o_per_wdata(o_per_wdata), .o_per_rdata(o_per_rdata),
    .o_per_rvalid(o_per_rvalid), .o_per_wr_drop(o_per_wr_drop), .i_mask_wdata(i_mask_wdata),
    .o_per_grp(o_per_grp));

// File: dv/prlk_top_tb_top.sv
`timescale 1ns/1ps
module prlk_top_tb_top;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_key_wr = 1'b0, i_key_rd = 1'b0, i_mask_wr = 1'b0, i_per_wr = 1'b0, i_per_rd = 1'b0;
    logic [7:0]  i_key_wdata = 8'h00;
    logic [15:0] i_mask_wdata = 16'h0000;
    logic [3:0]  i_per_grp = 4'h0;
    logic [31:0] i_per_wdata = 32'h0, i_per_rdata = 32'h0;
    logic [7:0]  o_key_rdata;
    logic [15:0] o_peripheral_lock_mask;
    logic [3:0]  o_per_grp;
    logic [31:0] o_per_rdata, o_per_wdata;
    logic        o_key_rvalid, o_mask_wr_rej, o_per_rvalid, o_per_wr, o_per_rd, o_per_wr_drop;
    int          bad_count = 0, cmp_count = 0, cyc = 0;

    prlk_top u_prlk_top (.i_clk(i_clk), .i_rst(i_rst), .i_key_wr(i_key_wr), .i_key_wdata(i_key_wdata),
        .i_key_rd(i_key_rd), .o_key_rdata(o_key_rdata), .o_key_rvalid(o_key_rvalid), .i_mask_wr(i_mask_wr),
        .i_mask_wdata(i_mask_wdata), .o_peripheral_lock_mask(o_peripheral_lock_mask),
        .o_mask_wr_rej(o_mask_wr_rej), .i_per_wr(i_per_wr), .i_per_rd(i_per_rd), .i_per_grp(i_per_grp),
        .i_per_wdata(i_per_wdata), .o_per_rdata(o_per_rdata), .o_per_rvalid(o_per_rvalid),
        .o_per_wr(o_per_wr), .o_per_rd(o_per_rd), .o_per_grp(o_per_grp), .o_per_wdata(o_per_wdata),
        .i_per_rdata(i_per_rdata), .o_per_wr_drop(o_per_wr_drop));

    // Clock and hang guard
    always #50 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            finish_test();
        end
    end

    task finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Bus cycle helpers
    task key(input logic [7:0] d);
        @(posedge i_clk);
        i_key_wr <= 1'b1;
        i_key_wdata <= d;
        @(posedge i_clk);
        i_key_wr <= 1'b0;
    endtask
    task key_rd(input logic [7:0] e);
        @(posedge i_clk);
        i_key_rd <= 1'b1;
        @(posedge i_clk);
        i_key_rd <= 1'b0;
        #1;
        chk(o_key_rvalid, 1'b1);
        chk(o_key_rdata, e);
    endtask
    task mask(input logic [15:0] d, input logic rej);
        @(posedge i_clk);
        i_mask_wr <= 1'b1;
        i_mask_wdata <= d;
        @(posedge i_clk);
        i_mask_wr <= 1'b0;
        #1;
        chk(o_mask_wr_rej, rej);
    endtask
    task pwr(input logic [3:0] g, input logic [31:0] d, input logic fwd);
        @(posedge i_clk);
        i_per_wr <= 1'b1;
        i_per_grp <= g;
        i_per_wdata <= d;
        @(posedge i_clk);
        i_per_wr <= 1'b0;
        #1;
        chk(o_per_wr, fwd);
        chk(o_per_grp, g);
        chk(o_per_wr_drop, !fwd);
        if (fwd) chk(o_per_wdata, d);
    endtask
    task prd(input logic [3:0] g, input logic [31:0] d);
        @(posedge i_clk);
        i_per_rd <= 1'b1;
        i_per_grp <= g;
        i_per_rdata <= d;
        @(posedge i_clk);
        i_per_rd <= 1'b0;
        #1;
        chk(o_per_rd, 1'b1);
        chk(o_per_grp, g);
        @(posedge i_clk);
        #1;
        chk(o_per_rvalid, 1'b1);
        chk(o_per_rdata, d);
    endtask

    // Scenarios
    task t_locked;
        chk(o_peripheral_lock_mask, 16'hffff);
        key_rd(8'h00);
        mask(16'h0000, 1'b1);
        chk(o_peripheral_lock_mask, 16'hffff);
        pwr(4'h3, 32'h1234_5678, 1'b0);
        prd(4'h3, 32'hcafe_0001);
    endtask
    task t_order;
        key(8'hc5);
        key(8'ha5);
        key_rd(8'h02);
        key(8'h33);
        key_rd(8'h00);
        key(8'ha5);
        key(8'ha5);
        key_rd(8'h02);
        key(8'hc5);
        key_rd(8'h01);
    endtask
    task t_open;
        mask(16'h00f0, 1'b0);
        chk(o_peripheral_lock_mask, 16'h00f0);
        pwr(4'h0, 32'h0bad_f00d, 1'b1);
        pwr(4'h4, 32'h5555_aaaa, 1'b0);
        pwr(4'h8, 32'ha5a5_0f0f, 1'b1);
        prd(4'h4, 32'h0000_beef);
    endtask
    task t_relock;
        key(8'hc5);
        key_rd(8'h00);
        mask(16'h0000, 1'b1);
        chk(o_peripheral_lock_mask, 16'h00f0);
    endtask

    initial begin
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        t_locked();
        t_order();
        t_open();
        t_relock();
        finish_test();
    end
endmodule
